// ==== hdl/mapinc_map.svh ====
// register offsets, field positions, encodings and reset values of the access port
// assumes byte addressing on apb, one 32-bit word per register
`ifndef MAPINC_MAP_SVH
`define MAPINC_MAP_SVH

`define MAPINC_CSW_OFF       8'h00
`define MAPINC_TAR_OFF       8'h04
`define MAPINC_STS_OFF       8'h08
`define MAPINC_DRW_OFF       8'h0c
`define MAPINC_BANK0_OFF     8'h10

`define MAPINC_ACCESS_WIDTH_FIELD_LSB  0
`define MAPINC_CSW_MODE_LSB  4
`define MAPINC_CSW_EN_BIT    6
`define MAPINC_STS_ERR_BIT   0
`define MAPINC_STS_BUSY_BIT  1

`define MAPINC_SIZE_BYTE     3'h0
`define MAPINC_SIZE_HALF     3'h1
`define MAPINC_SIZE_WORD     3'h2

`define MAPINC_MODE_OFF      2'h0
`define MAPINC_MODE_SINGLE   2'h1
`define MAPINC_MODE_PACKED   2'h2
`define MAPINC_MODE_RSVD     2'h3

`define MAPINC_SIZE_RST      3'h2
`define MAPINC_MODE_RST      2'h0
`define MAPINC_TAR_RST       32'h0000_0000

`endif

// ==== hdl/mapinc_pkg.sv ====
// types used by the access port design and its assertions
// assumes the constants of mapinc_map.svh
package mapinc_pkg;
   // gray order along idle -> busy -> done; the step done -> idle flips both bits
   typedef enum logic [1:0] {
      MAPINC_IDLE = 2'b00,
      MAPINC_BUSY = 2'b01,
      MAPINC_DONE = 2'b11
   } mapinc_state_e;
endpackage

// ==== hdl/mapinc.sv ====
// memory access port: apb register slave, enable gating and transfer address auto-increment
// assumes a memory side that answers each mem_req beat with a one-cycle mem_ack (mem_err with it)
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/10ps
`include "mapinc_map.svh"

module mapinc #(
   parameter int ADDR_W         = 8,
   parameter bit HAS_ENABLE_PIN = 1'b1,
   parameter bit SUBWORD        = 1'b1
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              target_access_allow_in,
   input  wire logic              abort_in,
   output logic                   mem_req,
   output logic                   mem_write,
   output logic      [31:0]       mem_addr,
   output logic      [2:0]        mem_size,
   output logic      [31:0]       mem_wdata,
   input  wire logic              mem_ack,
   input  wire logic              mem_err,
   input  wire logic [31:0]       mem_rdata
);

   generate
      if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
         $error("mapinc: ADDR_W must lie between 5 and 32");
      end
   endgenerate

   // packed support follows sub-word support
   localparam bit PACKED = SUBWORD;

   mapinc_pkg::mapinc_state_e state_ff;
   logic [2:0]        size_ff;
   logic [1:0]        mode_ff;
   logic [31:0]       tar_ff;
   logic              sticky_ff;
   logic              err_ff;
   logic              bank_ff;
   logic [1:0]        beats_left_ff;
   logic [31:0]       prdata_ff;
   logic              mem_req_ff;
   logic              mem_write_ff;
   logic [31:0]       mem_addr_ff;
   logic [31:0]       mem_wdata_ff;
   logic              sync1_ff;
   logic              sync2_ff;
   logic              sync3_ff;
   logic              en_ff;

   function automatic logic [31:0] incr_of(input logic [2:0] size);
      case (size)
         `MAPINC_SIZE_BYTE: incr_of = 32'h0000_0001;
         `MAPINC_SIZE_HALF: incr_of = 32'h0000_0002;
         default:           incr_of = 32'h0000_0004;
      endcase
   endfunction

   function automatic logic [31:0] lane_mask(input logic [2:0] size, input logic [1:0] lo);
      case (size)
         `MAPINC_SIZE_BYTE: lane_mask = 32'h0000_00ff << {lo, 3'h0};
         `MAPINC_SIZE_HALF: lane_mask = 32'h0000_ffff << {lo[1], 4'h0};
         default:           lane_mask = 32'hffff_ffff;
      endcase
   endfunction

   localparam logic [ADDR_W-1:0] CSW_A  = ADDR_W'(`MAPINC_CSW_OFF);
   localparam logic [ADDR_W-1:0] TAR_A  = ADDR_W'(`MAPINC_TAR_OFF);
   localparam logic [ADDR_W-1:0] STS_A  = ADDR_W'(`MAPINC_STS_OFF);
   localparam logic [ADDR_W-1:0] DRW_A  = ADDR_W'(`MAPINC_DRW_OFF);
   localparam logic [ADDR_W-1:0] BANK_A = ADDR_W'(`MAPINC_BANK0_OFF);

   logic        setup;
   logic        access;
   logic        hit_bank;
   logic        hit_drw;
   logic        hit_win;
   logic        hit_reg;
   logic        launch;
   logic        disabled_hit;
   logic        reg_wr;
   logic        beat_ok;
   logic        beat_last;
   logic        adv;
   logic [31:0] step;
   logic [31:0] tar_next;
   logic [1:0]  nbeats_m1;
   logic [31:0] rd_mux;

   assign setup    = psel & ~penable;
   assign access   = psel & penable;
   assign hit_bank = (paddr[ADDR_W-1:4] == BANK_A[ADDR_W-1:4]) && (paddr[1:0] == 2'h0);
   assign hit_drw  = (paddr == DRW_A);
   assign hit_win  = hit_bank | hit_drw;
   assign hit_reg  = (paddr == CSW_A) | (paddr == TAR_A) | (paddr == STS_A);

   // window accesses stall until the bus side answers; a disabled one answers at once
   assign pready  = ~(access & hit_win & (state_ff != mapinc_pkg::MAPINC_DONE)
                      & ((state_ff != mapinc_pkg::MAPINC_IDLE) | en_ff));
   assign pslverr = access & pready
                    & ((~hit_win & ~hit_reg)
                       | (hit_win & ((state_ff == mapinc_pkg::MAPINC_DONE) ? err_ff : 1'b1)));
   assign prdata  = prdata_ff;

   assign disabled_hit = access & hit_win & (state_ff == mapinc_pkg::MAPINC_IDLE) & ~en_ff;
   assign launch       = access & hit_win & (state_ff == mapinc_pkg::MAPINC_IDLE) & en_ff;
   assign reg_wr       = access & pwrite & hit_reg;

   assign step      = incr_of(size_ff);
   assign tar_next  = tar_ff + step;
   assign beat_ok   = (state_ff == mapinc_pkg::MAPINC_BUSY) & mem_ack & ~mem_err & ~abort_in;
   assign beat_last = (beats_left_ff == 2'h0);
   // banked windows and mode off never move the address
   assign adv       = beat_ok & ~bank_ff
                      & ((mode_ff == `MAPINC_MODE_SINGLE)
                         | (mode_ff == `MAPINC_MODE_PACKED));

   always_comb begin
      nbeats_m1 = 2'h0;
      if (PACKED && !hit_bank && mode_ff == `MAPINC_MODE_PACKED) begin
         if (size_ff == `MAPINC_SIZE_BYTE) begin
            nbeats_m1 = 2'h3;
         end else if (size_ff == `MAPINC_SIZE_HALF) begin
            nbeats_m1 = 2'h1;
         end
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (paddr == CSW_A) begin
         rd_mux[`MAPINC_ACCESS_WIDTH_FIELD_LSB +: 3] = size_ff;
         rd_mux[`MAPINC_CSW_MODE_LSB +: 2] = mode_ff;
         rd_mux[`MAPINC_CSW_EN_BIT]        = en_ff;
      end else if (paddr == TAR_A) begin
         rd_mux = tar_ff;
      end else if (paddr == STS_A) begin
         rd_mux[`MAPINC_STS_ERR_BIT]  = sticky_ff;
         rd_mux[`MAPINC_STS_BUSY_BIT] = (state_ff != mapinc_pkg::MAPINC_IDLE);
      end
   end

   // pin synchroniser; the level moves only once the second and third stages agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         sync3_ff <= 1'b0;
      end else begin
         sync1_ff <= target_access_allow_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // reset value 1 would let a window access slip through before the pin is seen; 0 is safe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_ff <= ~HAS_ENABLE_PIN;
      end else if (!HAS_ENABLE_PIN) begin
         en_ff <= 1'b1;
      end else if (sync2_ff == sync3_ff) begin
         en_ff <= sync3_ff;
      end
   end

   // control word; a word-only port keeps the width field fixed at word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         size_ff <= `MAPINC_SIZE_RST;
         mode_ff <= `MAPINC_MODE_RST;
      end else if (reg_wr && paddr == CSW_A) begin
         if (SUBWORD && pwdata[`MAPINC_ACCESS_WIDTH_FIELD_LSB +: 3] <= `MAPINC_SIZE_WORD) begin
            size_ff <= pwdata[`MAPINC_ACCESS_WIDTH_FIELD_LSB +: 3];
         end
         case (pwdata[`MAPINC_CSW_MODE_LSB +: 2])
            `MAPINC_MODE_OFF:    mode_ff <= `MAPINC_MODE_OFF;
            `MAPINC_MODE_SINGLE: mode_ff <= `MAPINC_MODE_SINGLE;
            `MAPINC_MODE_PACKED: mode_ff <= PACKED ? `MAPINC_MODE_PACKED
                                                   : `MAPINC_MODE_OFF;
            default:             mode_ff <= mode_ff;
         endcase
      end
   end

   // apb writes only land while idle, so they never race an increment
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tar_ff <= `MAPINC_TAR_RST;
      end else if (reg_wr && paddr == TAR_A) begin
         tar_ff <= pwdata;
      end else if (adv) begin
         tar_ff <= tar_next;
      end
   end

   // set wins over the write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sticky_ff <= 1'b0;
      end else begin
         sticky_ff <= disabled_hit
                      | ((state_ff == mapinc_pkg::MAPINC_BUSY) & mem_ack & mem_err)
                      | (sticky_ff & ~(reg_wr & (paddr == STS_A)
                                       & pwdata[`MAPINC_STS_ERR_BIT]));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff      <= mapinc_pkg::MAPINC_IDLE;
         err_ff        <= 1'b0;
         bank_ff       <= 1'b0;
         beats_left_ff <= 2'h0;
         mem_req_ff    <= 1'b0;
      end else begin
         case (state_ff)
            mapinc_pkg::MAPINC_IDLE: begin
               if (launch) begin
                  state_ff      <= mapinc_pkg::MAPINC_BUSY;
                  err_ff        <= 1'b0;
                  bank_ff       <= hit_bank;
                  beats_left_ff <= nbeats_m1;
                  mem_req_ff    <= 1'b1;
               end
            end
            mapinc_pkg::MAPINC_BUSY: begin
               if (abort_in || (mem_ack && mem_err)) begin
                  state_ff   <= mapinc_pkg::MAPINC_DONE;
                  err_ff     <= 1'b1;
                  mem_req_ff <= 1'b0;
               end else if (mem_ack) begin
                  if (beat_last) begin
                     state_ff   <= mapinc_pkg::MAPINC_DONE;
                     mem_req_ff <= 1'b0;
                  end else begin
                     beats_left_ff <= beats_left_ff - 2'h1;
                  end
               end
            end
            mapinc_pkg::MAPINC_DONE: begin
               state_ff <= mapinc_pkg::MAPINC_IDLE;
            end
            default: begin
               state_ff   <= mapinc_pkg::MAPINC_IDLE;
               mem_req_ff <= 1'b0;
            end
         endcase
      end
   end

   // bus side request fields, held stable for the whole beat
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_write_ff <= 1'b0;
         mem_addr_ff  <= 32'h0000_0000;
         mem_wdata_ff <= 32'h0000_0000;
      end else if (launch) begin
         mem_write_ff <= pwrite;
         mem_wdata_ff <= pwdata;
         mem_addr_ff  <= hit_bank ? {tar_ff[31:4], paddr[3:2], 2'h0} : tar_ff;
      end else if (beat_ok && !beat_last) begin
         mem_addr_ff  <= tar_next;
      end
   end

   // read data: register value at setup, then lanes gathered beat by beat
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup) begin
         prdata_ff <= rd_mux;
      end else if (launch) begin
         prdata_ff <= 32'h0000_0000;
      end else if (beat_ok && !mem_write_ff) begin
         prdata_ff <= (prdata_ff & ~lane_mask(mem_size, mem_addr_ff[1:0]))
                      | (mem_rdata & lane_mask(mem_size, mem_addr_ff[1:0]));
      end
   end

   assign mem_req   = mem_req_ff;
   assign mem_write = mem_write_ff;
   assign mem_addr  = mem_addr_ff;
   assign mem_size  = size_ff;
   assign mem_wdata = mem_wdata_ff;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_en_bit_read: assert property (
      setup && paddr == CSW_A |=> prdata[`MAPINC_CSW_EN_BIT] == $past(en_ff))
      else $error("enable bit read does not match enable level");
   chk_disabled_err: assert property (
      disabled_hit |-> pready && pslverr ##1 sticky_ff && !mem_req)
      else $error("disabled window access not refused with sticky error");
   chk_no_pin_one: assert property (
      !HAS_ENABLE_PIN |-> ##2 en_ff)
      else $error("enable bit not one without enable pin");
   chk_bank_fixed: assert property (
      state_ff == mapinc_pkg::MAPINC_BUSY && bank_ff && mem_ack |=> $stable(tar_ff))
      else $error("banked window moved the transfer address");
   chk_mode_legal: assert property (
      !PACKED |-> mode_ff != `MAPINC_MODE_PACKED && mode_ff != `MAPINC_MODE_RSVD)
      else $error("illegal increment mode held");
   chk_err_no_move: assert property (
      state_ff == mapinc_pkg::MAPINC_BUSY && (abort_in || (mem_ack && mem_err))
      |=> $stable(tar_ff) && !mem_req && pslverr == (psel && penable))
      else $error("failed access moved address or kept requesting");
   chk_off_fixed: assert property (
      mode_ff == `MAPINC_MODE_OFF && state_ff == mapinc_pkg::MAPINC_BUSY |=> $stable(tar_ff))
      else $error("address moved in increment off mode");
   chk_single_step: assert property (
      beat_ok && !bank_ff && mode_ff == `MAPINC_MODE_SINGLE
      |=> tar_ff == $past(tar_ff) + incr_of($past(size_ff)))
      else $error("single increment step wrong");
   chk_half_packed: assert property (
      launch && !hit_bank && mode_ff == `MAPINC_MODE_PACKED && size_ff == `MAPINC_SIZE_HALF
      |=> beats_left_ff == 2'h1)
      else $error("packed halfword access not two beats");
   chk_byte_packed: assert property (
      beat_ok && !bank_ff && mode_ff == `MAPINC_MODE_PACKED && size_ff == `MAPINC_SIZE_BYTE
      |=> tar_ff == $past(tar_ff) + 32'h0000_0001)
      else $error("packed byte step not one");

endmodule

// ==== dv/mapinc_mem.sv ====
// memory side model of the access port: answers each beat after a set delay
// assumes one beat outstanding, with the address held until the ack edge
`timescale 1ns/10ps

module mapinc_mem (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   input  wire logic [3:0]  delay,
   input  wire logic [3:0]  err_beat,
   output logic             mem_ack,
   output logic             mem_err,
   output logic [31:0]      mem_rdata
);
   logic [31:0] seen[$];
   logic [31:0] last_wdata;
   logic [3:0]  wait_ff;

   // no ack in the cycle after an ack: the next beat's address is not out yet
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ack <= 1'b0;
         mem_err <= 1'b0;
         mem_rdata <= 32'h0;
         wait_ff <= 4'h0;
      end else begin
         mem_ack <= 1'b0;
         mem_err <= 1'b0;
         // read data is garbage outside the ack cycle
         mem_rdata <= ~mem_rdata;
         if (!mem_req || mem_ack) begin
            wait_ff <= 4'h0;
         end else if (wait_ff != delay) begin
            wait_ff <= wait_ff + 4'h1;
         end else begin
            mem_ack <= 1'b1;
            mem_err <= (seen.size() + 1 == err_beat);
            mem_rdata <= {4{mem_addr[7:0] ^ 8'h5a}};
            last_wdata <= mem_wdata;
            seen.push_back(mem_addr);
         end
      end
   end
endmodule

// ==== dv/mapinc_bench.sv ====
// self-checking bench of the access port, apb master tasks and a memory model
// assumes register offsets and encodings of mapinc_map.svh
`timescale 1ns/10ps
`include "mapinc_map.svh"

module mapinc_bench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        allow = 1'b1;
   logic        abort_in = 1'b0;
   logic        mem_req;
   logic        mem_write;
   logic [31:0] mem_addr;
   logic [2:0]  mem_size;
   logic [31:0] mem_wdata;
   logic        mem_ack;
   logic        mem_err;
   logic [31:0] mem_rdata;
   logic [3:0]  delay = 4'h0;
   logic [3:0]  err_beat = 4'h0;
   logic [31:0] rq;
   logic [31:0] rq_w;
   logic        re;
   logic [31:0] prdata_w;
   logic        mem_req_w;
   int          comparisons = 0;
   int          fails = 0;
   int          cycles = 0;

   mapinc u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .target_access_allow_in(allow), .abort_in(abort_in),
      .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_size(mem_size),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata));

   mapinc_mem u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .delay(delay), .err_beat(err_beat), .mem_ack(mem_ack),
      .mem_err(mem_err), .mem_rdata(mem_rdata));

   // word-only port without an enable pin; its memory side acks every request at once
   mapinc #(.HAS_ENABLE_PIN(1'b0), .SUBWORD(1'b0)) u_dut_word (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata_w), .pready(), .pslverr(), .target_access_allow_in(allow),
      .abort_in(abort_in), .mem_req(mem_req_w), .mem_write(), .mem_addr(), .mem_size(),
      .mem_wdata(), .mem_ack(mem_req_w), .mem_err(1'b0), .mem_rdata(32'h0000_0000));

   always #20 pclk = ~pclk;

   task automatic stop_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         stop_test;
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // the answer is taken at the rising edge, before any design flop moves on it
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic r;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         r = pready;
         rq = prdata;
         rq_w = prdata_w;
         re = pslverr;
      end while (r !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic cfg(input logic [2:0] sz, input logic [1:0] md, input logic [31:0] t);
      apb(1'b1, `MAPINC_CSW_OFF, {26'h0, md, 1'b0, sz});
      apb(1'b1, `MAPINC_TAR_OFF, t);
      u_mem.seen.delete();
   endtask

   task automatic tar_is(input logic [31:0] exp);
      apb(1'b0, `MAPINC_TAR_OFF, 32'h0);
      chk("transfer_address", exp, rq);
   endtask

   task automatic t_enable;
      apb(1'b0, `MAPINC_CSW_OFF, 32'h0);
      chk("control_status_word", 32'h42, rq);
      allow <= 1'b0;
      repeat (5) @(posedge pclk);
      apb(1'b0, `MAPINC_CSW_OFF, 32'h0);
      chk("target_access_allowed_bit", 1'b0, rq[6]);
      apb(1'b1, `MAPINC_CSW_OFF, 32'h20);
      apb(1'b0, `MAPINC_CSW_OFF, 32'h0);
      chk("packed mode stored", 32'h20, rq);
      chk("word-only control_status_word", 32'h42, rq_w);
      apb(1'b1, `MAPINC_DRW_OFF, 32'h1234);
      chk("disabled write error", 1'b1, re);
      apb(1'b0, `MAPINC_BANK0_OFF + 8'h4, 32'h0);
      chk("disabled banked error", 1'b1, re);
      chk("disabled beats", 0, u_mem.seen.size());
      tar_is(32'h0);
      apb(1'b0, `MAPINC_STS_OFF, 32'h0);
      chk("sticky_error_flag", 1'b1, rq[0]);
      apb(1'b1, `MAPINC_STS_OFF, 32'h1);
      apb(1'b0, `MAPINC_STS_OFF, 32'h0);
      chk("sticky clear", 1'b0, rq[0]);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped error", 1'b1, re);
      allow <= 1'b1;
      repeat (5) @(posedge pclk);
   endtask

   task automatic t_single;
      logic [2:0]  sz[4] = '{`MAPINC_SIZE_WORD, `MAPINC_SIZE_WORD, `MAPINC_SIZE_HALF,
                             `MAPINC_SIZE_BYTE};
      logic [1:0]  md[4] = '{`MAPINC_MODE_OFF, `MAPINC_MODE_SINGLE, `MAPINC_MODE_SINGLE,
                             `MAPINC_MODE_SINGLE};
      logic [31:0] inc[4] = '{32'h0, 32'h4, 32'h2, 32'h1};
      for (int i = 0; i < 4; i++) begin
         cfg(sz[i], md[i], 32'h100);
         apb(1'b1, `MAPINC_DRW_OFF, 32'hc0de_0000 + i);
         chk("write response", 1'b0, re);
         chk("beat address", 32'h100, u_mem.seen[0]);
         chk("beat data", 32'hc0de_0000 + i, u_mem.last_wdata);
         chk("beat direction", 32'h1, mem_write);
         chk("access_width_field", sz[i], mem_size);
         tar_is(32'h100 + inc[i]);
      end
      apb(1'b1, `MAPINC_CSW_OFF, 32'h32);
      apb(1'b0, `MAPINC_CSW_OFF, 32'h0);
      chk("reserved mode kept", `MAPINC_MODE_SINGLE, rq[5:4]);
   endtask

   task automatic t_packed;
      delay <= 4'h2;
      cfg(`MAPINC_SIZE_HALF, `MAPINC_MODE_PACKED, 32'h100);
      apb(1'b0, `MAPINC_DRW_OFF, 32'h0);
      chk("packed half data", 32'h5858_5a5a, rq);
      chk("packed half beats", 2, u_mem.seen.size());
      chk("read direction", 32'h0, mem_write);
      chk("second beat address", 32'h102, u_mem.seen[1]);
      tar_is(32'h104);
      delay <= 4'h0;
      cfg(`MAPINC_SIZE_BYTE, `MAPINC_MODE_PACKED, 32'h3fe);
      apb(1'b1, `MAPINC_DRW_OFF, 32'h4433_2211);
      for (int i = 0; i < 4; i++) begin
         chk("byte beat address", 32'h3fe + i, u_mem.seen[i]);
      end
      tar_is(32'h402);
   endtask

   task automatic t_fail;
      err_beat <= 4'h2;
      cfg(`MAPINC_SIZE_BYTE, `MAPINC_MODE_PACKED, 32'h200);
      apb(1'b1, `MAPINC_DRW_OFF, 32'h0);
      err_beat <= 4'h0;
      chk("error response", 1'b1, re);
      chk("beats before error", 2, u_mem.seen.size());
      tar_is(32'h201);
      apb(1'b0, `MAPINC_STS_OFF, 32'h0);
      chk("sticky on bus error", 1'b1, rq[0]);
      apb(1'b1, `MAPINC_STS_OFF, 32'h1);
      delay <= 4'h6;
      cfg(`MAPINC_SIZE_WORD, `MAPINC_MODE_SINGLE, 32'h300);
      fork
         apb(1'b0, `MAPINC_DRW_OFF, 32'h0);
         begin
            repeat (4) @(posedge pclk);
            abort_in <= 1'b1;
            @(posedge pclk);
            abort_in <= 1'b0;
         end
      join
      delay <= 4'h0;
      chk("abort response", 1'b1, re);
      tar_is(32'h300);
   endtask

   task automatic t_banked;
      cfg(`MAPINC_SIZE_WORD, `MAPINC_MODE_SINGLE, 32'h12c);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, `MAPINC_BANK0_OFF + 8'(4 * i), 32'h0);
         chk("banked address", 32'h120 + 4 * i, u_mem.seen[i]);
      end
      tar_is(32'h12c);
   endtask

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      t_enable;
      t_single;
      t_packed;
      t_fail;
      t_banked;
      stop_test;
   end
endmodule
